// ---- src/pes_pkg.sv ----
package pes_pkg;
   localparam int EVT_W = 8;
   localparam int QUAL_W = 8;
   localparam int AMT_W = 8;
   localparam int CNT_W = 48;
   localparam int SUPERQUEUE_W = 6;
   localparam int DEL_W = 3;
   // event numbers
   localparam logic [7:0] EV_MOVE_ELIM = 8'h58;
   localparam logic [7:0] EV_PRIV_CYC = 8'h5c;
   localparam logic [7:0] EV_SCHED_EMPTY = 8'h5e;
   localparam logic [7:0] EV_SUPERQUEUE_OUTSTANDING = 8'h60;
   localparam logic [7:0] EV_LOCK_CYC = 8'h63;
   localparam logic [7:0] EV_UOP_QUEUE = 8'h79;
   // qualifier bits
   localparam int Q_B0 = 0;
   localparam int Q_B1 = 1;
   localparam int Q_B2 = 2;
   localparam int Q_B3 = 3;
   localparam int Q_B4 = 4;
   localparam int Q_B5 = 5;
   localparam logic [7:0] Q_01 = 8'h01;
   localparam logic [7:0] Q_02 = 8'h02;
   localparam logic [7:0] Q_04 = 8'h04;
   localparam logic [7:0] Q_08 = 8'h08;
   localparam logic [7:0] Q_ALL_PATHS = 8'h3c;
   localparam logic [7:0] THR_ONE = 8'h01;
   localparam logic [7:0] THR_FOUR = 8'h04;
   // host register map (word addresses on the plain port)
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CNT_LO = 4'h1;
   localparam logic [3:0] REG_CNT_HI = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam int CTRL_EVT_LSB = 0;
   localparam int CTRL_QUAL_LSB = 8;
   localparam int CTRL_THR_LSB = 16;
   localparam int CTRL_EDGE_BIT = 24;
   localparam int CTRL_EN_BIT = 25;
   localparam int CTRL_CLR_BIT = 26;
   localparam int CTRL_SMT_BIT = 27;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage : pes_pkg

// ---- src/pes_if.sv ----
`timescale 1ns/100ps
interface pes_if;
   logic [7:0] evt_sel;
   logic [7:0] qual_sel;
   logic [7:0] thr;
   logic edge_en;
   logic count_en;
   logic count_clr;
   logic [47:0] count;
   modport device (input evt_sel, input qual_sel, input thr, input edge_en, input count_en,
      input count_clr, output count);
   modport host (output evt_sel, output qual_sel, output thr, output edge_en, output count_en,
      output count_clr, input count);
endinterface : pes_if

// ---- src/pes_device.sv ----
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module pes_device (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   pes_if.device bus,
   input wire logic i_unhalted,
   input wire logic i_ring_zero,
   input wire logic [1:0] i_int_elim,
   input wire logic [1:0] i_int_not_elim,
   input wire logic [1:0] i_simd_elim,
   input wire logic [1:0] i_simd_not_elim,
   input wire logic i_sched_empty,
   input wire logic [5:0] i_superqueue_data_rd,
   input wire logic [5:0] i_superqueue_code_rd,
   input wire logic [5:0] i_superqueue_read_for_ownership,
   input wire logic [5:0] i_superqueue_all_data_rd,
   input wire logic i_lock_both,
   input wire logic i_lock_first_level,
   input wire logic i_uop_queue_empty,
   input wire logic [2:0] i_legacy_uops,
   input wire logic [2:0] i_uop_cache_uops,
   input wire logic [2:0] i_seq_cache_uops,
   input wire logic [2:0] i_seq_legacy_uops,
   output logic [7:0] o_amount
);
   logic [7:0] amt_move, amt_priv, amt_superqueue, amt_lock, amt_queue, amt_sel;
   logic [7:0] t_int_elim, t_simd_elim, t_int_not_elim, t_simd_not_elim;
   logic [7:0] t_ring_zero, t_outer_ring, t_sched_empty;
   logic [7:0] t_superqueue_data, t_superqueue_code, t_superqueue_ownership, t_superqueue_all_data;
   logic [7:0] t_lock_both, t_lock_first_level;
   logic [7:0] t_queue_empty, t_legacy, t_uop_cache, t_seq_cache, t_seq_legacy;
   logic priv_ring_zero, priv_outer;
   logic [7:0] ev;
   logic [7:0] q;
   logic cond_d, cond_q, inc_cond;
   logic [47:0] cnt_q, cnt_d;
   logic [7:0] amount_q;

   assign ev = bus.evt_sel;
   assign q = bus.qual_sel;

   // each qualifier bit gates its own source, so combined bits give the union
   pes_term #(.W(2)) i_int_elim_term (
      .i_en(q[pes_pkg::Q_B0]),
      .i_val(i_int_elim),
      .o_amt(t_int_elim)
   );
   pes_term #(.W(2)) i_simd_elim_term (
      .i_en(q[pes_pkg::Q_B1]),
      .i_val(i_simd_elim),
      .o_amt(t_simd_elim)
   );
   pes_term #(.W(2)) i_int_not_elim_term (
      .i_en(q[pes_pkg::Q_B2]),
      .i_val(i_int_not_elim),
      .o_amt(t_int_not_elim)
   );
   pes_term #(.W(2)) i_simd_not_elim_term (
      .i_en(q[pes_pkg::Q_B3]),
      .i_val(i_simd_not_elim),
      .o_amt(t_simd_not_elim)
   );
   assign amt_move = t_int_elim + t_simd_elim + t_int_not_elim + t_simd_not_elim;

   // halted cycles never count at any privilege level
   assign priv_ring_zero = i_unhalted & i_ring_zero;
   assign priv_outer = i_unhalted & ~i_ring_zero;
   pes_term #(.W(1)) i_ring_zero_term (
      .i_en(q[pes_pkg::Q_B0]),
      .i_val(priv_ring_zero),
      .o_amt(t_ring_zero)
   );
   pes_term #(.W(1)) i_outer_ring_term (
      .i_en(q[pes_pkg::Q_B1]),
      .i_val(priv_outer),
      .o_amt(t_outer_ring)
   );
   assign amt_priv = t_ring_zero + t_outer_ring;

   pes_term #(.W(1)) i_sched_empty_term (
      .i_en(q[pes_pkg::Q_B0]),
      .i_val(i_sched_empty),
      .o_amt(t_sched_empty)
   );

   pes_term #(.W(6)) i_superqueue_data_term (
      .i_en(q[pes_pkg::Q_B0]),
      .i_val(i_superqueue_data_rd),
      .o_amt(t_superqueue_data)
   );
   pes_term #(.W(6)) i_superqueue_code_term (
      .i_en(q[pes_pkg::Q_B1]),
      .i_val(i_superqueue_code_rd),
      .o_amt(t_superqueue_code)
   );
   pes_term #(.W(6)) i_superqueue_ownership_term (
      .i_en(q[pes_pkg::Q_B2]),
      .i_val(i_superqueue_read_for_ownership),
      .o_amt(t_superqueue_ownership)
   );
   pes_term #(.W(6)) i_superqueue_all_data_term (
      .i_en(q[pes_pkg::Q_B3]),
      .i_val(i_superqueue_all_data_rd),
      .o_amt(t_superqueue_all_data)
   );
   // four full occupancies still fit the 8-bit amount
   assign amt_superqueue = t_superqueue_data + t_superqueue_code + t_superqueue_ownership
      + t_superqueue_all_data;

   pes_term #(.W(1)) i_lock_both_term (
      .i_en(q[pes_pkg::Q_B0]),
      .i_val(i_lock_both),
      .o_amt(t_lock_both)
   );
   pes_term #(.W(1)) i_lock_first_level_term (
      .i_en(q[pes_pkg::Q_B1]),
      .i_val(i_lock_first_level),
      .o_amt(t_lock_first_level)
   );
   // a locked cycle counts once even with both qualifier bits set
   assign amt_lock = t_lock_both | t_lock_first_level;

   pes_term #(.W(1)) i_queue_empty_term (
      .i_en(q[pes_pkg::Q_B1]),
      .i_val(i_uop_queue_empty),
      .o_amt(t_queue_empty)
   );
   pes_term #(.W(3)) i_legacy_term (
      .i_en(q[pes_pkg::Q_B2]),
      .i_val(i_legacy_uops),
      .o_amt(t_legacy)
   );
   pes_term #(.W(3)) i_uop_cache_term (
      .i_en(q[pes_pkg::Q_B3]),
      .i_val(i_uop_cache_uops),
      .o_amt(t_uop_cache)
   );
   pes_term #(.W(3)) i_seq_cache_term (
      .i_en(q[pes_pkg::Q_B4]),
      .i_val(i_seq_cache_uops),
      .o_amt(t_seq_cache)
   );
   pes_term #(.W(3)) i_seq_legacy_term (
      .i_en(q[pes_pkg::Q_B5]),
      .i_val(i_seq_legacy_uops),
      .o_amt(t_seq_legacy)
   );
   // per-source terms summed across set bits
   assign amt_queue = t_queue_empty + t_legacy + t_uop_cache + t_seq_cache + t_seq_legacy;

   always_comb begin
      case (ev)
         pes_pkg::EV_MOVE_ELIM: amt_sel = amt_move;
         pes_pkg::EV_PRIV_CYC: amt_sel = amt_priv;
         pes_pkg::EV_SCHED_EMPTY: amt_sel = t_sched_empty;
         pes_pkg::EV_SUPERQUEUE_OUTSTANDING: amt_sel = amt_superqueue;
         pes_pkg::EV_LOCK_CYC: amt_sel = amt_lock;
         pes_pkg::EV_UOP_QUEUE: amt_sel = amt_queue;
         default: amt_sel = 8'h00;
      endcase
   end

   // threshold zero with edge off means raw amount; otherwise one per qualifying cycle
   assign cond_d = (bus.thr == 8'h00) ? (amt_sel != 8'h00) : (amt_sel >= bus.thr);
   // edge: only a false-to-true change of the condition counts
   assign inc_cond = bus.edge_en ? (cond_d & ~cond_q) : cond_d;
   always_comb begin
      cnt_d = cnt_q;
      if (bus.count_clr) begin
         cnt_d = 48'h0;
      end else if (bus.count_en) begin
         if ((bus.thr == 8'h00) && !bus.edge_en) begin
            cnt_d = cnt_q + {40'h0, amt_sel};
         end else if (inc_cond) begin
            cnt_d = cnt_q + 48'h1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= 48'h0;
         cond_q <= 1'b0;
         amount_q <= 8'h00;
      end else if (i_ce) begin
         cnt_q <= cnt_d;
         cond_q <= bus.count_en & cond_d;
         amount_q <= amt_sel;
      end
   end

   assign bus.count = cnt_q;
   assign o_amount = amount_q;
endmodule : pes_device

module pes_term #(
   parameter int W = 2
) (
   input wire logic i_en,
   input wire logic [W-1:0] i_val,
   output logic [7:0] o_amt
);
   // zero-extend to the common amount width so the sums never wrap
   assign o_amt = i_en ? {{(8 - W){1'b0}}, i_val} : 8'h00;
endmodule : pes_term

// ---- src/pes_host.sv ----
`timescale 1ns/100ps
// superqueue events are refused while multithreading is flagged on
module pes_host (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   pes_if.host bus,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_refused
);
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] rdata_q, rdata_d;
   logic clr_q, refused_q;
   logic wr_ctrl, superqueue_sel, smt_on;

   assign wr_ctrl = i_wr && (i_addr == pes_pkg::REG_CTRL);
   assign superqueue_sel = i_wdata[pes_pkg::CTRL_EVT_LSB +: 8] == pes_pkg::EV_SUPERQUEUE_OUTSTANDING;
   assign smt_on = i_wdata[pes_pkg::CTRL_SMT_BIT];
   // refuse enabling superqueue events with multithreading on
   assign ctrl_d = (superqueue_sel && smt_on) ? {i_wdata[31:26], 1'b0, i_wdata[24:0]} : i_wdata;

   always_comb begin
      case (i_addr)
         pes_pkg::REG_CTRL: rdata_d = ctrl_q;
         pes_pkg::REG_CNT_LO: rdata_d = bus.count[31:0];
         pes_pkg::REG_CNT_HI: rdata_d = {16'h0, bus.count[47:32]};
         pes_pkg::REG_STATUS: rdata_d = {31'h0, refused_q};
         default: rdata_d = 32'h0;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_q <= pes_pkg::CTRL_RST;
         clr_q <= 1'b0;
         refused_q <= 1'b0;
         rdata_q <= 32'h0;
      end else if (i_ce) begin
         if (wr_ctrl) begin
            ctrl_q <= ctrl_d;
            refused_q <= superqueue_sel && smt_on;
         end
         clr_q <= wr_ctrl && i_wdata[pes_pkg::CTRL_CLR_BIT];
         rdata_q <= i_rd ? rdata_d : 32'h0;
      end
   end

   // threshold field passed through as written
   assign bus.evt_sel = ctrl_q[pes_pkg::CTRL_EVT_LSB +: 8];
   assign bus.qual_sel = ctrl_q[pes_pkg::CTRL_QUAL_LSB +: 8];
   assign bus.thr = ctrl_q[pes_pkg::CTRL_THR_LSB +: 8];
   assign bus.edge_en = ctrl_q[pes_pkg::CTRL_EDGE_BIT];
   assign bus.count_en = ctrl_q[pes_pkg::CTRL_EN_BIT];
   assign bus.count_clr = clr_q;
   assign o_rdata = rdata_q;
   assign o_refused = refused_q;
endmodule : pes_host

// ---- sim/pes_assertions.sv ----
`timescale 1ns/100ps
module pes_checker (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic [7:0] evt_sel,
   input wire logic [7:0] qual_sel,
   input wire logic [7:0] thr,
   input wire logic edge_en,
   input wire logic count_en,
   input wire logic count_clr,
   input wire logic [47:0] count
);
   logic [25:0] cfg_q;
   logic [1:0] st_q;
   logic [47:0] cnt_q;
   wire logic [25:0] cfg_d = {evt_sel, qual_sel, thr, edge_en, count_en};
   // a clear or a config change in this cycle makes the step meaningless
   wire logic st = (st_q == 2'h3) && (cfg_d == cfg_q) && !count_clr;
   wire logic [47:0] dc = count - cnt_q;
   // settled config only: the count pipeline lags a control write
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_q <= '0;
         st_q <= 2'h0;
         cnt_q <= '0;
      end else begin
         cfg_q <= cfg_d;
         cnt_q <= count;
         st_q <= (cfg_d != cfg_q) ? 2'h0 : st_q + {1'b0, !st};
      end
   end
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);
   property p_clear; count_clr |-> ##[1:2] count == 48'h0; endproperty
   a_clear: assert property (p_clear) else $error("count not cleared");
   property p_hold; st && !count_en |=> dc == 48'h0; endproperty
   a_hold: assert property (p_hold) else $error("count moved while disabled");
   property p_thr_step; st && thr != 8'h0 |=> dc <= 48'h1; endproperty
   a_thr_step: assert property (p_thr_step) else $error("threshold step above one");
   property p_edge_gap; st && edge_en && dc != 48'h0 |=> dc == 48'h0; endproperty
   a_edge_gap: assert property (p_edge_gap) else $error("edge count on two cycles");
   property p_edge_one; st && edge_en && dc != 48'h0 |-> dc == 48'h1; endproperty
   a_edge_one: assert property (p_edge_one) else $error("edge step not one");
   property p_mono; st |=> count >= cnt_q; endproperty
   a_mono: assert property (p_mono) else $error("count went down");
   property p_level; st && (evt_sel == pes_pkg::EV_PRIV_CYC || evt_sel == pes_pkg::EV_SCHED_EMPTY) |=> dc <= 48'h1;
   endproperty
   a_level: assert property (p_level) else $error("level event step above one");
   property p_superqueue;
      st && evt_sel == pes_pkg::EV_SUPERQUEUE_OUTSTANDING && qual_sel == pes_pkg::Q_01 |=> dc <= 48'h3f;
   endproperty
   a_superqueue: assert property (p_superqueue) else $error("occupancy step too large");
   c_clear: cover property (count_clr);
   c_edge: cover property (st && edge_en && dc == 48'h1);
   c_thr: cover property (st && thr == pes_pkg::THR_FOUR && dc == 48'h1);
endmodule : pes_checker

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
   logic i_ref_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [49:0] sv = '0;
   logic [31:0] o_rdata;
   logic [7:0] amount;
   logic o_refused;
   logic [31:0] rd_v;
   logic [47:0] exp_cnt;
   integer seed = 34;
   int num_errors = 0;
   int total_checks = 0;
   logic [24:0] cases [28] = '{25'h0000858, 25'h0000158, 25'h0000258,
      25'h000015c, 25'h100015c, 25'h000025c, 25'h000015e,
      25'h0000160, 25'h0000260, 25'h0000460, 25'h0000860, 25'h0010160,
      25'h0000163, 25'h0000263, 25'h0000279, 25'h0000479, 25'h0000879,
      25'h0001079, 25'h1001079, 25'h0002079, 25'h0003079,
      25'h0011879, 25'h0041879, 25'h0012479, 25'h0042479, 25'h0002479, 25'h0003c79,
      25'h0000180};
   always #10 i_ref_clk = ~i_ref_clk;
   pes_if i_pes_if ();
   pes_device i_pes_device (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(1'b1), .bus(i_pes_if.device),
      .i_unhalted(sv[0]), .i_ring_zero(sv[1]), .i_int_elim(sv[3:2]), .i_int_not_elim(sv[5:4]),
      .i_simd_elim(sv[7:6]), .i_simd_not_elim(sv[9:8]), .i_sched_empty(sv[10]),
      .i_superqueue_data_rd(sv[16:11]), .i_superqueue_code_rd(sv[22:17]),
      .i_superqueue_read_for_ownership(sv[28:23]), .i_superqueue_all_data_rd(sv[34:29]), .i_lock_both(sv[35]),
      .i_lock_first_level(sv[36]), .i_uop_queue_empty(sv[37]), .i_legacy_uops(sv[40:38]),
      .i_uop_cache_uops(sv[43:41]), .i_seq_cache_uops(sv[46:44]), .i_seq_legacy_uops(sv[49:47]),
      .o_amount(amount));
   pes_host i_pes_host (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(1'b1), .bus(i_pes_if.host),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_refused(o_refused));
   pes_checker i_pes_checker (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .evt_sel(i_pes_if.evt_sel),
      .qual_sel(i_pes_if.qual_sel), .thr(i_pes_if.thr), .edge_en(i_pes_if.edge_en),
      .count_en(i_pes_if.count_en), .count_clr(i_pes_if.count_clr), .count(i_pes_if.count));
   function automatic logic [7:0] amt(input logic [49:0] s, input logic [7:0] e, input logic [7:0] q);
      case (e)
         pes_pkg::EV_MOVE_ELIM: return 8'(s[3:2] & {2{q[0]}}) + 8'(s[7:6] & {2{q[1]}})
            + 8'(s[5:4] & {2{q[2]}}) + 8'(s[9:8] & {2{q[3]}});
         pes_pkg::EV_PRIV_CYC: return 8'(s[0] & (q[0] & s[1] | q[1] & !s[1]));
         pes_pkg::EV_SCHED_EMPTY: return 8'(q[0] & s[10]);
         pes_pkg::EV_SUPERQUEUE_OUTSTANDING: return 8'(s[16:11] & {6{q[0]}}) + 8'(s[22:17] & {6{q[1]}})
            + 8'(s[28:23] & {6{q[2]}}) + 8'(s[34:29] & {6{q[3]}});
         pes_pkg::EV_LOCK_CYC: return 8'(q[0] & s[35]) + 8'(q[1] & s[36]);
         pes_pkg::EV_UOP_QUEUE: return 8'(q[1] & s[37]) + 8'(s[40:38] & {3{q[2]}}) + 8'(s[43:41] & {3{q[3]}})
            + 8'(s[46:44] & {3{q[4]}}) + 8'(s[49:47] & {3{q[5]}});
         default: return 8'h0;
      endcase
   endfunction : amt
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 rd_v = o_rdata;
   endtask : rd
   task automatic cnt_chk(input logic [47:0] e);
      rd(pes_pkg::REG_CNT_LO);
      chk(rd_v, e[31:0]);
      rd(pes_pkg::REG_CNT_HI);
      chk(rd_v, {16'h0, e[47:32]});
   endtask : cnt_chk
   // idle cycles around the burst keep edge state and pipeline lag out of the sum
   task automatic burst(input logic [24:0] c, input logic flat);
      logic [49:0] s;
      logic [7:0] a;
      logic cond;
      logic prev;
      logic [7:0] pa;
      prev = 1'b0;
      pa = 8'h00;
      repeat (2) @(posedge i_ref_clk);
      for (int i = 0; i < 24; i++) begin
         @(posedge i_ref_clk);
         s = flat ? '1 : 50'({$random(seed), $random(seed)});
         sv <= s;
         a = amt(s, c[7:0], c[15:8]);
         cond = (c[23:16] == 8'h0) ? a != 8'h0 : a >= c[23:16];
         if (c[24]) exp_cnt += 48'(cond && !prev);
         else if (c[23:16] != 8'h0) exp_cnt += 48'(cond);
         else exp_cnt += 48'(a);
         prev = cond;
         // registered amount shows the previous cycle's inputs
         @(negedge i_ref_clk);
         chk({24'h0, amount}, {24'h0, pa});
         pa = a;
      end
      @(posedge i_ref_clk);
      sv <= '0;
      repeat (4) @(posedge i_ref_clk);
   endtask : burst
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      rd(pes_pkg::REG_CTRL);
      chk(rd_v, pes_pkg::CTRL_RST);
      rd(4'h7);
      chk(rd_v, 32'h0);
      for (int p = 0; p < 2; p++) begin
         foreach (cases[k]) begin
            wr(pes_pkg::REG_CTRL, 32'h0600_0000 | 32'(cases[k]));
            exp_cnt = '0;
            burst(cases[k], p[0]);
            chk({31'h0, o_refused}, 32'h0);
            cnt_chk(exp_cnt);
         end
      end
      wr(pes_pkg::REG_CTRL, 32'h0e00_0160);
      burst(25'h0000160, 1'b0);
      chk({31'h0, o_refused}, 32'h1);
      rd(pes_pkg::REG_STATUS);
      chk(rd_v & 32'h1, 32'h1);
      cnt_chk(48'h0);
      complete_run();
   end
endmodule : tb
